// >>> shared/sbclk_pkg.sv
// Package for the bus clock gear control block: register map, field layout,
// reset values, gear limits and loop reference select codes.
// Assumes one system clock domain; every pin input is synchronised in the block.
package sbclk_pkg;

    // Register map
    localparam logic [15:0] SBCLK_GEAR_CTRL_ADDR   = 16'h05E3;  // bus_framer_reference_gear_control
    localparam logic [15:0] SBCLK_GEAR_CTRL_RESET  = 16'h0004;
    localparam int          SBCLK_SRC_SEL_BIT      = 4;          // framer_clock_source_select
    localparam int          SBCLK_REF_GEAR_MSB     = 3;          // reference_gear_select [3:0]
    localparam int          SBCLK_REF_GEAR_LSB     = 0;

    // Gear figures
    localparam logic [3:0]  SBCLK_GEAR_STOP        = 4'h0;
    localparam logic [3:0]  SBCLK_GEAR_MIN         = 4'h1;
    localparam logic [3:0]  SBCLK_GEAR_MAX         = 4'hA;
    localparam int          SBCLK_DIV_BITS         = 9;          // Divide by up to 512

    // Loop reference select codes
    localparam logic        SBCLK_LOOP_SRC_EXT     = 1'h0;
    localparam logic        SBCLK_LOOP_SRC_BUS     = 1'h1;
    localparam int          SBCLK_LOOP_MAX         = 8;
    localparam int          SBCLK_LOOP_DEFAULT     = 2;

    // Synchroniser pair for one pin
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } sbclk_sync_t;

    // Whole state of the block
    typedef struct packed {
        sbclk_sync_t                      bus_pin;
        sbclk_sync_t                      main_clk;
        sbclk_sync_t                      async_clk;
        sbclk_sync_t                      ext_ref;
        logic [SBCLK_DIV_BITS-1:0]        fr_cnt;
        logic [SBCLK_DIV_BITS-1:0]        rx_cnt;
        logic                             src_sel;
        logic [3:0]                       ref_gear;
        logic                             pin_o;
        logic                             pin_oe;
        logic                             ref_clk;
        logic                             ref_valid;
        logic [SBCLK_LOOP_MAX-1:0]        loop_ref;
        logic [15:0]                      rdata;
    } sbclk_state_t;

endpackage : sbclk_pkg

// >>> test/sbclk_gear_ctrl_chk.sv
// Assertions on the ports of the gear control block.
// Assumes one clock domain and gears 1 to 10 on the bus.
`timescale 1ns/1ns
module sbclk_gear_ctrl_chk
    import sbclk_pkg::*;
(
    input wire logic        SYS_CLK_I,
    input wire logic        RST_I,
    input wire logic        CE_I,
    input wire logic        FRAMER_ACTIVE_I,
    input wire logic [3:0]  BUS_GEAR_I,
    input wire logic        BUS_CLK_PIN_O,
    input wire logic        BUS_CLK_PIN_OE_O,
    input wire logic        BUS_REF_CLK_O,
    input wire logic        BUS_REF_VALID_O,
    input wire logic [15:0] REG_ADDR_I,
    input wire logic        REG_WR_I,
    input wire logic [15:0] REG_WDATA_I,
    input wire logic        REG_RD_I,
    input wire logic [15:0] REG_RDATA_O
);
    logic [4:0] sh_reg;
    logic [3:0] eff;
    logic       hit;
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    assign hit = REG_ADDR_I == SBCLK_GEAR_CTRL_ADDR;
    assign eff = (sh_reg[3:0] > SBCLK_GEAR_MAX) ? SBCLK_GEAR_MAX : sh_reg[3:0];
    // Shadow of the control word
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) sh_reg <= 5'h04;
        else if (CE_I && REG_WR_I && hit) sh_reg <= REG_WDATA_I[4:0];
    end
    oe_follow_a: assert property (CE_I |=> BUS_CLK_PIN_OE_O == $past(FRAMER_ACTIVE_I))
        else $error("pin enable does not follow role");
    pin_idle_a: assert property (!FRAMER_ACTIVE_I |=> !BUS_CLK_PIN_O)
        else $error("pin driven while not framing");
    frm_noref_a: assert property (FRAMER_ACTIVE_I |=> !BUS_REF_VALID_O)
        else $error("reference on while framing");
    ref_quiet_a: assert property (!BUS_REF_VALID_O |-> !BUS_REF_CLK_O)
        else $error("reference toggles while disabled");
    gear_low_a: assert property (eff == 4'h0 || BUS_GEAR_I < eff |=> !BUS_REF_VALID_O)
        else $error("reference on below its gear");
    ref_on_a: assert property (!FRAMER_ACTIVE_I && eff != 4'h0 && BUS_GEAR_I >= eff
        |=> BUS_REF_VALID_O) else $error("reference off although reachable");
    rd_resv_a: assert property (REG_RDATA_O[15:5] == 11'h000)
        else $error("reserved bits read nonzero");
    rd_unmap_a: assert property (REG_RD_I && !hit |=> REG_RDATA_O == 16'h0000)
        else $error("unmapped read nonzero");
    rd_word_a: assert property (REG_RD_I && !REG_WR_I && hit
        |=> REG_RDATA_O[4:0] == $past(sh_reg)) else $error("read data wrong");
endmodule : sbclk_gear_ctrl_chk
bind sbclk_gear_ctrl sbclk_gear_ctrl_chk u_chk (.SYS_CLK_I, .RST_I, .CE_I, .FRAMER_ACTIVE_I,
    .BUS_GEAR_I, .BUS_CLK_PIN_O, .BUS_CLK_PIN_OE_O, .BUS_REF_CLK_O, .BUS_REF_VALID_O,
    .REG_ADDR_I, .REG_WR_I, .REG_WDATA_I, .REG_RD_I, .REG_RDATA_O);

// >>> test/sbclk_gear_ctrl_test.sv
// Self-checking bench for the gear control block with a bus manager model.
// Assumes system clocks of 4 and 6 cycles period and two loops.
`timescale 1ns/1ns
module sbclk_gear_ctrl_test
    import sbclk_pkg::*;
;
    logic        ce = 1;
    logic        clk = 0, rst = 1, mclk = 0, aclk = 0, ext = 0, wr = 0, rd = 0, fr_req = 0;
    logic [3:0]  g_req = 4'hA;
    logic [1:0]  sel = 2'h0, lref;
    logic [15:0] addr = 16'h0000, wd = 16'h0000, rdata;
    logic        pin_o, pin_oe, pin_i, fa, ref_c, ref_v;
    logic [3:0]  gear;
    int          fail_count = 0, checks_done = 0, cyc = 0, p;
    initial forever #50 clk = ~clk;
    always #200 mclk = ~mclk;
    always #300 aclk = ~aclk;
    sbclk_mgr_model u_sbclk_mgr_model (.clk_i(clk), .framer_req_i(fr_req), .gear_req_i(g_req),
        .pin_drv_i(pin_o), .pin_en_i(pin_oe), .framer_o(fa), .gear_o(gear), .pin_lvl_o(pin_i));
    sbclk_gear_ctrl #(.NUM_LOOPS(2)) u_sbclk_gear_ctrl (.SYS_CLK_I(clk), .RST_I(rst),
        .CE_I(ce), .FRAMER_ACTIVE_I(fa), .BUS_GEAR_I(gear), .MAIN_SYS_CLK_I(mclk),
        .ASYNC_SYS_CLK_I(aclk), .BUS_CLK_PIN_I(pin_i), .BUS_CLK_PIN_O(pin_o),
        .BUS_CLK_PIN_OE_O(pin_oe), .EXT_REF_I(ext), .LOOP_REF_SEL_I(sel), .LOOP_REF_O(lref),
        .BUS_REF_CLK_O(ref_c), .BUS_REF_VALID_O(ref_v), .REG_ADDR_I(addr), .REG_WR_I(wr),
        .REG_WDATA_I(wd), .REG_RD_I(rd), .REG_RDATA_O(rdata));
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk); addr = a; wd = d; wr = 1;
        @(negedge clk); wr = 0;
    endtask : wr_reg
    task automatic rd_reg(input logic [15:0] a, input logic [15:0] e);
        @(negedge clk); addr = a; rd = 1;
        @(negedge clk); rd = 0;
        check(rdata, e);
    endtask : rd_reg
    // Cycles between the third and fourth rising edge of reference (0), pin (1) or loop 0 (2)
    task automatic per(input logic [1:0] src, output int pr);
        int e = 0, t = 0;
        logic l = 1, c;
        pr = 0;
        repeat (4000) begin
            @(negedge clk);
            c = (src == 2'h1) ? pin_o : (src == 2'h2) ? lref[0] : ref_c;
            t++;
            if (c === 1'b1 && l === 1'b0) begin e++; if (e == 4) pr = t; t = 0; end
            l = c;
        end
    endtask : per
    task automatic t_reg;
        rd_reg(SBCLK_GEAR_CTRL_ADDR, 16'h0004);
        wr_reg(SBCLK_GEAR_CTRL_ADDR, 16'hFFFF); rd_reg(SBCLK_GEAR_CTRL_ADDR, 16'h001F);
        wr_reg(16'h05E4, 16'h0000); rd_reg(SBCLK_GEAR_CTRL_ADDR, 16'h001F);
        rd_reg(16'h05E4, 16'h0000);
        // A write with the clock enable low must not land
        ce = 0;
        wr_reg(SBCLK_GEAR_CTRL_ADDR, 16'h0000);
        ce = 1;
        rd_reg(SBCLK_GEAR_CTRL_ADDR, 16'h001F);
        // Reset in mid-run brings back the default word and releases the pin
        rst = 1;
        repeat (2) @(negedge clk);
        rst = 0;
        rd_reg(SBCLK_GEAR_CTRL_ADDR, 16'h0004);
        check(16'(pin_oe), 16'h0000);
        $display("register test done");
    endtask : t_reg
    task automatic t_ref;
        logic [3:0] rg[5] = '{4'h4, 4'h4, 4'hC, 4'h0, 4'h5}, bg[5] = '{10, 6, 10, 10, 4};
        int         ex[5] = '{256, 256, 4, 0, 0};
        fr_req = 0;
        for (int i = 0; i < 5; i++) begin
            wr_reg(SBCLK_GEAR_CTRL_ADDR, {12'h000, rg[i]}); g_req = bg[i];
            repeat (20) @(negedge clk);
            check(16'(ref_v), 16'(ex[i] != 0));
            if (ex[i] != 0) begin per(2'h0, p); check(16'(p), 16'(ex[i])); end
        end
        $display("reference test done");
    endtask : t_ref
    task automatic t_frm;
        logic sr[4] = '{0, 0, 0, 1};
        logic [3:0] fg[4] = '{9, 8, 10, 9};
        int ex[4] = '{8, 16, 4, 12};
        fr_req = 1;
        for (int i = 0; i < 4; i++) begin
            wr_reg(SBCLK_GEAR_CTRL_ADDR, {11'h000, sr[i], 4'h4}); g_req = fg[i];
            repeat (20) @(negedge clk);
            check(16'(pin_oe), 16'h0001);
            per(2'h1, p); check(16'(p), 16'(ex[i]));
        end
        fr_req = 0; g_req = 4'hA; repeat (4) @(negedge clk);
        check(16'(pin_oe), 16'h0000);
        $display("framer test done");
    endtask : t_frm
    task automatic t_loop;
        wr_reg(SBCLK_GEAR_CTRL_ADDR, 16'h0000); sel = 2'h1; ext = 1;
        repeat (8) @(negedge clk); check(16'(lref), 16'h0002);
        sel = 2'h2; repeat (8) @(negedge clk); check(16'(lref), 16'h0001);
        ext = 0; repeat (8) @(negedge clk); check(16'(lref), 16'h0000);
        // A running bus reference must reach the loop that selects it
        wr_reg(SBCLK_GEAR_CTRL_ADDR, 16'h000A); sel = 2'h1;
        per(2'h2, p); check(16'(p), 16'h0004);
        $display("loop select test done");
    endtask : t_loop
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (10) @(negedge clk);
        rst = 0;
        t_reg(); t_ref(); t_frm(); t_loop();
        print_verdict();
    end
endmodule : sbclk_gear_ctrl_test

// >>> test/sbclk_mgr_model.sv
// Bus manager and bus-side clock model for the gear control bench.
// Assumes the bench drives its requests at the falling edge of clk_i.
`timescale 1ns/1ns
module sbclk_mgr_model (
    input  wire logic       clk_i,
    input  wire logic       framer_req_i,
    input  wire logic [3:0] gear_req_i,
    input  wire logic       pin_drv_i,
    input  wire logic       pin_en_i,
    output logic            framer_o,
    output logic [3:0]      gear_o,
    output logic            pin_lvl_o
);
    logic [10:0] cnt = 11'h000;
    initial begin
        framer_o = 1'b0;
        gear_o   = 4'hA;
    end
    // Role and gear broadcast away from the sampling edge, root clock counter
    always @(negedge clk_i) begin
        framer_o <= framer_req_i;
        gear_o   <= gear_req_i;
        cnt      <= cnt + 11'h001;
    end
    // Wire level: the device wins while it drives, else the geared bus clock
    assign pin_lvl_o = pin_en_i ? pin_drv_i : cnt[4'hB - gear_o];
endmodule : sbclk_mgr_model

// >>> verilog/sbclk_gear_ctrl.sv
// Bus clock gear control: drives or receives the bus clock pin and derives a
// gear-tracking reference for the frequency locked loops.
// Assumes the current bus gear and framer role come from bus logic on SYS_CLK_I,
// and that the system clocks and bus clock pin arrive asynchronously.
// Clock inputs are sampled, so each level must last at least two SYS_CLK_I periods.
// A gear step moves a divider tap, so the first period after it may be short.
// Functional notes
// - The bus clock pin is driven while the device is active framer and is an input otherwise.
// - The manager moves the framer role and the pin direction follows the role input one SYS_CLK_I cycle later.
// - Gear 10 passes the root frequency and each lower gear halves it, gear 1 dividing by 512.
// - The framer clock follows the main system clock when the select bit is 0, else the async clock.
// - When not framing the received bus clock gives a loop reference at the reference gear.
// - The reference divider tracks the current bus gear so the output stays at the reference gear.
// - The reference is disabled while the bus gear is below the reference gear.
// - Reference gear 0 stops the clock, 1 to 10 pick the gear, reset value is 4.
// - Each loop picks the bus reference or the shared external reference EXT_REF_I through its select bit.
// - Bus clock frequency changes need no reset or reconfiguration.
`timescale 1ns/1ns

module sbclk_gear_ctrl
    import sbclk_pkg::*;
#(
    parameter int NUM_LOOPS = SBCLK_LOOP_DEFAULT
) (
    input  wire logic                 SYS_CLK_I,
    input  wire logic                 RST_I,
    input  wire logic                 CE_I,
    input  wire logic                 FRAMER_ACTIVE_I,
    input  wire logic [3:0]           BUS_GEAR_I,
    input  wire logic                 MAIN_SYS_CLK_I,
    input  wire logic                 ASYNC_SYS_CLK_I,
    input  wire logic                 BUS_CLK_PIN_I,
    output logic                      BUS_CLK_PIN_O,
    output logic                      BUS_CLK_PIN_OE_O,
    input  wire logic                 EXT_REF_I,
    input  wire logic [NUM_LOOPS-1:0] LOOP_REF_SEL_I,
    output logic [NUM_LOOPS-1:0]      LOOP_REF_O,
    output logic                      BUS_REF_CLK_O,
    output logic                      BUS_REF_VALID_O,
    input  wire logic [15:0]          REG_ADDR_I,
    input  wire logic                 REG_WR_I,
    input  wire logic [15:0]          REG_WDATA_I,
    input  wire logic                 REG_RD_I,
    output logic [15:0]               REG_RDATA_O
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (NUM_LOOPS < 1 || NUM_LOOPS > SBCLK_LOOP_MAX) begin : g_bad_loops
        $error("NUM_LOOPS out of range");
    end

    // Divider must be deep enough for the slowest gear
    if (SBCLK_DIV_BITS < int'(SBCLK_GEAR_MAX - SBCLK_GEAR_MIN)) begin : g_bad_div
        $error("SBCLK_DIV_BITS too small for the gear range");
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Tap of a ripple divider: 0 passes the level, n picks divide by 2^n
    // Counter bit n-1 toggles once per 2^(n-1) counted edges
    function automatic logic div_tap(input logic [SBCLK_DIV_BITS-1:0] cnt,
                                     input logic level, input logic [3:0] n);
        logic [3:0] idx;
        idx = n - 4'h1;
        if (n == 4'h0) begin
            div_tap = level;
        end else begin
            div_tap = cnt[idx];
        end
    endfunction : div_tap

    // Clamp a gear code into 1..10
    // Bus gear 0 is read as 1 and codes above 10 as 10
    function automatic logic [3:0] clamp_gear(input logic [3:0] g);
        if (g < SBCLK_GEAR_MIN) begin
            clamp_gear = SBCLK_GEAR_MIN;
        end else if (g > SBCLK_GEAR_MAX) begin
            clamp_gear = SBCLK_GEAR_MAX;
        end else begin
            clamp_gear = g;
        end
    endfunction : clamp_gear

    // All state lives in one register: outputs read it directly, and a low
    // clock enable holds the dividers, synchronisers and control word alike
    sbclk_state_t state_reg;
    sbclk_state_t state_next;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Synchronise pins, run dividers, decode register access
    always_comb begin
        logic [3:0] bus_gear;
        logic [3:0] ref_gear;
        logic [3:0] fr_shift;
        logic       fr_level;
        logic       fr_rise;
        logic       rx_rise;
        logic       ref_on;
        logic       ref_lvl;
        bus_gear   = clamp_gear(BUS_GEAR_I);
        ref_gear   = clamp_gear(state_reg.ref_gear);
        fr_shift   = SBCLK_GEAR_MAX - bus_gear;
        fr_level   = 1'h0;
        fr_rise    = 1'h0;
        rx_rise    = 1'h0;
        ref_on     = 1'h0;
        ref_lvl    = 1'h0;
        state_next = state_reg;

        // Two-stage synchronisers, edge history on the second stage
        // Only the second stage feeds logic; the first may be metastable
        state_next.bus_pin   = '{BUS_CLK_PIN_I,   state_reg.bus_pin.meta,   state_reg.bus_pin.sync};
        state_next.main_clk  = '{MAIN_SYS_CLK_I,  state_reg.main_clk.meta,  state_reg.main_clk.sync};
        state_next.async_clk = '{ASYNC_SYS_CLK_I, state_reg.async_clk.meta, state_reg.async_clk.sync};
        state_next.ext_ref   = '{EXT_REF_I,       state_reg.ext_ref.meta,   state_reg.ext_ref.sync};

        // Framer clock source choice
        // Both clocks are synchronised all the time, so a source change acts at once
        if (state_reg.src_sel) begin
            fr_level = state_reg.async_clk.sync;
            fr_rise  = state_reg.async_clk.sync & ~state_reg.async_clk.prev;
        end else begin
            fr_level = state_reg.main_clk.sync;
            fr_rise  = state_reg.main_clk.sync & ~state_reg.main_clk.prev;
        end

        // Framer divider, free running so gear changes need no restart
        if (fr_rise) begin
            state_next.fr_cnt = state_reg.fr_cnt + 1'b1;
        end

        // Receive divider counts synchronised rising edges of the bus pin
        rx_rise = state_reg.bus_pin.sync & ~state_reg.bus_pin.prev;
        if (rx_rise) begin
            state_next.rx_cnt = state_reg.rx_cnt + 1'b1;
        end

        // Pin direction follows the framer role; the drive value is forced low
        // while receiving so a later handover starts from a quiet level
        state_next.pin_oe = FRAMER_ACTIVE_I;
        if (FRAMER_ACTIVE_I) begin
            state_next.pin_o = div_tap(state_reg.fr_cnt, fr_level, fr_shift);
        end else begin
            state_next.pin_o = 1'h0;
        end

        // Reference divider adapts to the current bus gear: the tap is the gap
        // between bus gear and reference gear, so a gear step needs no restart.
        // An unreachable reference is held low rather than run at a wrong rate.
        ref_on = !FRAMER_ACTIVE_I && (state_reg.ref_gear != SBCLK_GEAR_STOP)
                 && (bus_gear >= ref_gear);
        if (ref_on) begin
            ref_lvl = div_tap(state_reg.rx_cnt, state_reg.bus_pin.sync,
                              bus_gear - ref_gear);
        end
        state_next.ref_clk   = ref_lvl;
        state_next.ref_valid = ref_on;

        // Per-loop reference choice
        state_next.loop_ref = '0;
        for (int i = 0; i < NUM_LOOPS; i++) begin
            if (LOOP_REF_SEL_I[i] == SBCLK_LOOP_SRC_BUS) begin
                state_next.loop_ref[i] = ref_lvl;
            end else begin
                state_next.loop_ref[i] = state_reg.ext_ref.sync;
            end
        end

        // Register write and read
        if (REG_WR_I && REG_ADDR_I == SBCLK_GEAR_CTRL_ADDR) begin
            state_next.src_sel  = REG_WDATA_I[SBCLK_SRC_SEL_BIT];
            state_next.ref_gear = REG_WDATA_I[SBCLK_REF_GEAR_MSB:SBCLK_REF_GEAR_LSB];
        end

        // Reads see the word before any write of the same cycle; reserved bits are zero
        if (REG_RD_I && REG_ADDR_I == SBCLK_GEAR_CTRL_ADDR) begin
            state_next.rdata = '0;
            state_next.rdata[SBCLK_SRC_SEL_BIT] = state_reg.src_sel;
            state_next.rdata[SBCLK_REF_GEAR_MSB:SBCLK_REF_GEAR_LSB] = state_reg.ref_gear;
        end else if (REG_RD_I) begin
            state_next.rdata = '0;                                        // Unmapped reads zero
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Synchronous reset, clock enable freezes everything.
    // Reset does not wait for the clock enable, so the control word always
    // returns to its reset value.
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            state_reg          <= '0;
            state_reg.src_sel  <= SBCLK_GEAR_CTRL_RESET[SBCLK_SRC_SEL_BIT];
            state_reg.ref_gear <= SBCLK_GEAR_CTRL_RESET[SBCLK_REF_GEAR_MSB:SBCLK_REF_GEAR_LSB];
        end else if (CE_I) begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Pin drive and its enable
    assign BUS_CLK_PIN_O    = state_reg.pin_o;
    assign BUS_CLK_PIN_OE_O = state_reg.pin_oe;

    // Derived reference and its valid flag
    assign BUS_REF_CLK_O    = state_reg.ref_clk;
    assign BUS_REF_VALID_O  = state_reg.ref_valid;

    // Per-loop references and read data
    assign LOOP_REF_O       = state_reg.loop_ref[NUM_LOOPS-1:0];
    assign REG_RDATA_O      = state_reg.rdata;

endmodule : sbclk_gear_ctrl
